/* File: rtl/acc_top.sv */
/*
  Converter control: APB registers, start sequencer, divider, pin sharing.
  Assumes the analog side presents its settled code on CONV_RAW.
*/
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module acc_top (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [acc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [acc_pkg::DATA_W-1:0] PWDATA,
  output logic [acc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [acc_pkg::RES_W-1:0] CONV_RAW,
  input wire logic [acc_pkg::PIN_N-1:0] PORT_OUT,
  input wire logic [acc_pkg::PIN_N-1:0] PORT_OE,
  input wire logic [acc_pkg::PIN_N-1:0] PORT_PULLUP,
  output logic [acc_pkg::PIN_N-1:0] PIN_OUT,
  output logic [acc_pkg::PIN_N-1:0] PIN_OE,
  output logic [acc_pkg::PIN_N-1:0] PIN_PULLUP_EN,
  output logic [acc_pkg::PIN_N-1:0] PIN_ANALOG_EN,
  output logic CONV_POWER_EN,
  output logic CONV_RESET,
  output logic CONV_SAMPLE,
  output logic CONV_CONVERT,
  output logic CONV_TICK,
  output logic [2:0] CHAN_SEL,
  output logic REF_SEL_EXT,
  output logic CONV_IRQ
);
  import acc_pkg::*;

  logic start_reg;
  logic start_prev_reg;
  logic power_off_reg;
  logic mode_reg;
  logic spare_reg;
  logic [2:0] chan_reg;
  logic ref_sel_reg;
  logic opa_sel_reg;
  logic [2:0] div_sel_reg;
  logic irq_flag_reg;
  logic conv_irq_en_reg;
  logic group_irq_en_reg;
  logic global_irq_en_reg;
  logic [PIN_N-1:0] func_sel_reg;
  logic done_n_reg;
  logic [RES_W-1:0] result_reg;
  logic [RES_W-1:0] raw_meta_reg;
  logic [RES_W-1:0] raw_sync_reg;
  logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_reg;
  logic [3:0] cnt_reg;
  logic [4:0] chk_ticks_reg;
  acc_state_t state_reg;
  logic tick;
  logic wr_en;
  logic start_fell;
  logic settled;
  logic end_evt;
  logic [DATA_W-1:0] rdata_next;
  logic hit_next;

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so reads are registered and stable

  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

  always_comb begin
    rdata_next = '0;
    hit_next = 1'b1;
    case (PADDR)
      OFS_CTRL_A: begin
        rdata_next[CA_START] = start_reg;
        rdata_next[CA_DONE_N] = done_n_reg;
        rdata_next[CA_POWER_OFF] = power_off_reg;
        rdata_next[CA_MODE] = mode_reg;
        rdata_next[CA_SPARE] = spare_reg;
        rdata_next[2:0] = chan_reg;
      end
      OFS_CTRL_B: begin
        rdata_next[CB_TEST] = 1'b1;
        rdata_next[CB_REF_SEL] = ref_sel_reg;
        rdata_next[CB_OPA_SEL] = opa_sel_reg;
        rdata_next[2:0] = div_sel_reg;
      end
      // R20: result split
      OFS_RESULT_LOW: rdata_next[7:0] = result_reg[7:0];
      OFS_RESULT_HIGH: rdata_next[RES_W-9:0] = result_reg[RES_W-1:8];
      OFS_IRQ: begin
        rdata_next[IRQ_FLAG] = irq_flag_reg;
        rdata_next[IRQ_CONV_EN] = conv_irq_en_reg;
        rdata_next[IRQ_GROUP_EN] = group_irq_en_reg;
        rdata_next[IRQ_GLOBAL_EN] = global_irq_en_reg;
      end
      OFS_PORT_B_FUNC: rdata_next[PIN_N-1:0] = func_sel_reg;
      default: hit_next = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? '0 : rdata_next;
      PSLVERR <= ~hit_next;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_reg <= 1'b0;
      power_off_reg <= 1'b1;
      mode_reg <= 1'b0;
      spare_reg <= 1'b0;
      chan_reg <= CHAN_RST;
    end else if (wr_en && PADDR == OFS_CTRL_A) begin
      start_reg <= PWDATA[CA_START];
      power_off_reg <= PWDATA[CA_POWER_OFF];
      mode_reg <= PWDATA[CA_MODE];
      spare_reg <= PWDATA[CA_SPARE];
      chan_reg <= PWDATA[2:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_sel_reg <= 1'b0;
      opa_sel_reg <= 1'b0;
      div_sel_reg <= DIV_RST;
    end else if (wr_en && PADDR == OFS_CTRL_B) begin
      ref_sel_reg <= PWDATA[CB_REF_SEL];
      opa_sel_reg <= PWDATA[CB_OPA_SEL];
      div_sel_reg <= PWDATA[2:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      conv_irq_en_reg <= 1'b0;
      group_irq_en_reg <= 1'b0;
      global_irq_en_reg <= 1'b0;
      func_sel_reg <= FUNC_RST;
    end else if (wr_en && PADDR == OFS_IRQ) begin
      conv_irq_en_reg <= PWDATA[IRQ_CONV_EN];
      group_irq_en_reg <= PWDATA[IRQ_GROUP_EN];
      global_irq_en_reg <= PWDATA[IRQ_GLOBAL_EN];
    end else if (wr_en && PADDR == OFS_PORT_B_FUNC) begin
      func_sel_reg <= PWDATA[PIN_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power settling: starts made before it elapses are ignored

  assign settled = (settle_reg == SETTLE_CYCLES[$bits(settle_reg)-1:0]);

  // R7: settle after power-on
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      settle_reg <= '0;
    end else if (power_off_reg) begin
      settle_reg <= '0;
    end else if (!settled) begin
      settle_reg <= settle_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  assign start_fell = start_prev_reg & ~start_reg;
  assign end_evt = tick && state_reg == ACC_CONVERT && cnt_reg == 4'(TOTAL_TICKS - 1);

  acc_clk_div u_div (
    .clk(REF_CLK),
    .rst_n(RESETN),
    // Stop on the end or abort edge so no stray tick leaks into idle
    .run(state_reg != ACC_IDLE && !end_evt && !start_reg && !power_off_reg),
    .sel(div_sel_reg),
    .tick(tick)
  );

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_reg;
    end
  end

  // R1: launch on falling start
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ACC_IDLE;
      cnt_reg <= 4'h0;
    end else if (power_off_reg || start_reg) begin
      state_reg <= ACC_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        ACC_IDLE: begin
          if (start_fell && settled) begin
            state_reg <= ACC_SAMPLE;
          end
        end
        // R12: 4 sampling clocks
        ACC_SAMPLE: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'(SAMPLE_TICKS - 1)) begin
              state_reg <= ACC_CONVERT;
            end
          end
        end
        ACC_CONVERT: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (end_evt) begin
              state_reg <= ACC_IDLE;
            end
          end
        end
        default: state_reg <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      done_n_reg <= 1'b1;
    end else if (start_reg) begin
      // R2: start high clears done
      done_n_reg <= 1'b0;
    end else if (start_fell && settled && !power_off_reg) begin
      // R21: busy until the end
      done_n_reg <= 1'b1;
    end else if (end_evt) begin
      // R3: done goes low
      done_n_reg <= 1'b0;
    end
  end

  // Raw code is held steady by the analog side, so a plain two-stage sync serves
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      raw_meta_reg <= '0;
      raw_sync_reg <= '0;
      result_reg <= '0;
    end else begin
      raw_meta_reg <= CONV_RAW;
      raw_sync_reg <= raw_meta_reg;
      if (end_evt) begin
        result_reg <= raw_sync_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt request: set wins over a software clear

  // R4: request flag and gated interrupt
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_flag_reg <= 1'b0;
      CONV_IRQ <= 1'b0;
    end else begin
      if (end_evt) begin
        irq_flag_reg <= 1'b1;
      end else if (wr_en && PADDR == OFS_IRQ && !PWDATA[IRQ_FLAG]) begin
        irq_flag_reg <= 1'b0;
      end
      CONV_IRQ <= irq_flag_reg & conv_irq_en_reg & group_irq_en_reg & global_irq_en_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Converter and pin outputs

  acc_pin_mux #(.N(PIN_N)) u_pins (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .func_sel(func_sel_reg),
    .port_out(PORT_OUT),
    .port_oe(PORT_OE),
    .port_pullup(PORT_PULLUP),
    .pin_out(PIN_OUT),
    .pin_oe(PIN_OE),
    .pin_pullup_en(PIN_PULLUP_EN),
    .pin_analog_en(PIN_ANALOG_EN)
  );

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CONV_POWER_EN <= 1'b0;
    end else begin
      CONV_POWER_EN <= ~power_off_reg;
    end
  end

  assign CONV_RESET = start_reg;
  assign CONV_SAMPLE = state_reg[0];
  assign CONV_CONVERT = state_reg[1];
  assign CONV_TICK = tick;
  // R18: channel route
  assign CHAN_SEL = chan_reg;
  // R9: reference choice
  // R19: 1 selects ext pin
  assign REF_SEL_EXT = ref_sel_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      chk_ticks_reg <= 5'h00;
    end else if (state_reg == ACC_IDLE) begin
      chk_ticks_reg <= 5'h00;
    end else if (tick) begin
      chk_ticks_reg <= chk_ticks_reg + 5'h01;
    end
  end

  property p_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
    start_reg |=> !done_n_reg && state_reg == ACC_IDLE;
  endproperty
  a_hold: assert property (p_hold) else $error("start high did not hold reset"); // R2

  property p_launch;
    @(posedge REF_CLK) disable iff (!RESETN)
    start_fell && settled && !power_off_reg |=> state_reg == ACC_SAMPLE && done_n_reg;
  endproperty
  a_launch: assert property (p_launch) else $error("start pulse did not launch"); // R21

  property p_nolaunch;
    @(posedge REF_CLK) disable iff (!RESETN)
    state_reg == ACC_IDLE && !start_fell |=> state_reg == ACC_IDLE;
  endproperty
  a_nolaunch: assert property (p_nolaunch) else $error("conversion without pulse"); // R1

  property p_sample;
    @(posedge REF_CLK) disable iff (!RESETN)
    $rose(state_reg == ACC_CONVERT) |-> chk_ticks_reg == 5'h04;
  endproperty
  a_sample: assert property (p_sample) else $error("sampling not 4 clocks"); // R12

  property p_done;
    @(posedge REF_CLK) disable iff (!RESETN)
    end_evt |-> chk_ticks_reg == 5'h0F ##1 !done_n_reg && irq_flag_reg;
  endproperty
  a_done: assert property (p_done) else $error("end not after 16 clocks"); // R3

  property p_irq;
    @(posedge REF_CLK) disable iff (!RESETN)
    CONV_IRQ |-> $past(irq_flag_reg && conv_irq_en_reg && group_irq_en_reg && global_irq_en_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without all enables"); // R4

  property p_div1;
    @(posedge REF_CLK) disable iff (!RESETN)
    state_reg == ACC_SAMPLE && div_sel_reg == DIV_1 && $past(state_reg) == ACC_SAMPLE |-> tick;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided clock missed a tick"); // R5

  property p_settle;
    @(posedge REF_CLK) disable iff (!RESETN)
    power_off_reg |=> state_reg == ACC_IDLE && !settled;
  endproperty
  a_settle: assert property (p_settle) else $error("runs while powered off"); // R7

  property p_pin;
    @(posedge REF_CLK) disable iff (!RESETN)
    ##1 (PIN_ANALOG_EN & (PIN_OE | PIN_PULLUP_EN | PIN_OUT)) == '0;
  endproperty
  a_pin: assert property (p_pin) else $error("analog pin still driven or pulled"); // R10

endmodule // acc_top

/* File: rtl/acc_pkg.sv */
/*
  Constants, types and helpers of the converter control block.
  Assumes one 100 MHz clock and a 32-bit APB register bus.
*/
// Function
// R1: A high-then-low pulse on the start bit launches one conversion.
// R2: While start is high, hold the converter in reset and done flag low.
// R3: Done flag (active low) goes to 0 when a conversion finishes.
// R4: Conversion end sets the request flag; interrupt out only when enabled.
// R5: Divider select 100=/1,000=/2,101=/4,001=/8,110=/16,010=/32; 011,111 undefined.
// R6: Software keeps the conversion clock period between 0.5us and 10us.
// R7: Converter powered while power-off is 0; starts wait a settling delay.
// R8: Software sets power-off whenever the converter is unused.
// R9: Reference chosen between supply and external pin by one select bit.
// R10: Analog-selected pin loses its port function and its pull-high.
// R11: Analog selection overrides the pin direction control.
// R12: Conversion is 4 sampling plus 12 converting clocks, 16 in all.
// R13: Interrupt use needs global, group and converter enables all high.
// R14: Software clears start before the pulse for a clean low-high-low.
// R15: Software reads results only after done goes low or interrupt.
// R16: Setup order: divider, power on, channel, pins, interrupt enables.
// R17: A polling user may leave converter interrupts disabled.
// R18: A 3-bit channel field selects the signal routed to the converter.
// R19: Reference select 0 means supply, 1 means external reference pin.
// R20: Result is 12 bits, split over low and high result registers.
// R21: Falling start edge launches the 16 clocks; done stays high until end.
package acc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 12;
  localparam int PIN_N = 8;

  ////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h08;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_IRQ = 8'h10;
  localparam logic [7:0] OFS_PORT_B_FUNC = 8'h14;

  localparam int CA_START = 7;
  localparam int CA_DONE_N = 6;
  localparam int CA_POWER_OFF = 5;
  localparam int CA_MODE = 4;
  localparam int CA_SPARE = 3;
  localparam int CB_TEST = 7;
  localparam int CB_REF_SEL = 4;
  localparam int CB_OPA_SEL = 3;
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_CONV_EN = 1;
  localparam int IRQ_GROUP_EN = 2;
  localparam int IRQ_GLOBAL_EN = 3;

  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [7:0] FUNC_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////
  localparam logic [2:0] DIV_1 = 3'b100;
  localparam logic [2:0] DIV_2 = 3'b000;
  localparam logic [2:0] DIV_4 = 3'b101;
  localparam logic [2:0] DIV_8 = 3'b001;
  localparam logic [2:0] DIV_16 = 3'b110;
  localparam logic [2:0] DIV_32 = 3'b010;

  localparam int SAMPLE_TICKS = 4;
  localparam int CONV_TICKS = 12;
  localparam int TOTAL_TICKS = SAMPLE_TICKS + CONV_TICKS;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_SAMPLE = 2'b01,
    ACC_CONVERT = 2'b10
  } acc_state_t;

  // Divider terminal count; undefined codes fall back to the slowest rate
  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    case (sel)
      DIV_1: div_mask = 5'h00;
      DIV_2: div_mask = 5'h01;
      DIV_4: div_mask = 5'h03;
      DIV_8: div_mask = 5'h07;
      DIV_16: div_mask = 5'h0F;
      default: div_mask = 5'h1F;
    endcase
  endfunction

endpackage

/* File: rtl/acc_clk_div.sv */
/*
  Conversion clock divider: one-cycle tick per conversion clock.
  Assumes run stays high for a whole conversion.
*/
`timescale 1ns/1ps
module acc_clk_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  import acc_pkg::*;

  logic [4:0] cnt_reg;

  // R5: divider select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 5'h00;
      tick <= 1'b0;
    end else if (cnt_reg == div_mask(sel)) begin
      cnt_reg <= 5'h00;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
      tick <= 1'b0;
    end
  end
endmodule // acc_clk_div

/* File: rtl/acc_pin_mux.sv */
/*
  Port B pin sharing between port logic and analog inputs.
  Assumes port drive, direction and pull-high come from same-clock logic.
*/
`timescale 1ns/1ps
module acc_pin_mux #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] func_sel,
  input wire logic [N-1:0] port_out,
  input wire logic [N-1:0] port_oe,
  input wire logic [N-1:0] port_pullup,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_pullup_en,
  output logic [N-1:0] pin_analog_en
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup_en <= '0;
      pin_analog_en <= '0;
    end else begin
      pin_out <= port_out & ~func_sel;
      // R11: direction overridden
      pin_oe <= port_oe & ~func_sel;
      // R10: pull-high removed
      pin_pullup_en <= port_pullup & ~func_sel;
      pin_analog_en <= func_sel;
    end
  end
endmodule // acc_pin_mux

/* File: tb/tb.sv */
/*
  Self-checking bench of the converter control block: APB tasks and scenarios.
  Assumes APB answers in two access cycles and power settles in SETTLE_CYCLES clocks.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb;
  import acc_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [DATA_W-1:0] PWDATA = '0;
  logic [DATA_W-1:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [RES_W-1:0] CONV_RAW = '0;
  logic [PIN_N-1:0] PORT_OUT = '0;
  logic [PIN_N-1:0] PORT_OE = '0;
  logic [PIN_N-1:0] PORT_PULLUP = '0;
  logic [PIN_N-1:0] PIN_OUT, PIN_OE, PIN_PULLUP_EN, PIN_ANALOG_EN;
  logic CONV_POWER_EN, CONV_RESET, CONV_SAMPLE, CONV_CONVERT, CONV_TICK;
  logic [2:0] CHAN_SEL;
  logic REF_SEL_EXT, CONV_IRQ;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int n_tests = 0;
  // Undefined codes are expected to run at the slowest rate
  // at 100 MHz every code is below 0.5us, which costs only accuracy
  logic [2:0] codes [8] = '{DIV_1, DIV_2, DIV_4, DIV_8, DIV_16, DIV_32, 3'b011, 3'b111};
  int ratio [8] = '{1, 2, 4, 8, 16, 32, 32, 32};

  always #5 REF_CLK = ~REF_CLK;

  acc_top DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CONV_RAW(CONV_RAW), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE),
    .PORT_PULLUP(PORT_PULLUP), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_ANALOG_EN(PIN_ANALOG_EN),
    .CONV_POWER_EN(CONV_POWER_EN), .CONV_RESET(CONV_RESET), .CONV_SAMPLE(CONV_SAMPLE),
    .CONV_CONVERT(CONV_CONVERT), .CONV_TICK(CONV_TICK), .CHAN_SEL(CHAN_SEL),
    .REF_SEL_EXT(REF_SEL_EXT), .CONV_IRQ(CONV_IRQ));

  ////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    fails++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask

  // Request held until the edge where PREADY is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1) break;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n == 50) timeout();
  endtask

  ////////////////////////////////////////////////////////////////////
  // One full start pulse, then phase lengths, ticks, flags and result
  task automatic conv(input logic [2:0] dv, input int n, input logic irq);
    int i, busy, smp, tk;
    logic [11:0] raw;
    raw = (dv == DIV_32) ? 12'hFFF : {dv, dv, dv, dv};
    CONV_RAW <= raw;
    apb(1'b1, OFS_CTRL_B, {29'h0, dv});
    apb(1'b1, OFS_CTRL_A, 32'h0000_0085);
    apb(1'b1, OFS_CTRL_A, 32'h0000_0005);
    busy = 0;
    smp = 0;
    tk = 0;
    for (i = 0; i < 2000; i++) begin
      @(posedge REF_CLK);
      #1;
      if (CONV_TICK === 1'b1) tk++;
      if (CONV_SAMPLE === 1'b1) smp++;
      if (CONV_SAMPLE === 1'b1 || CONV_CONVERT === 1'b1) busy++;
      else if (busy > 0) break;
    end
    if (i == 2000) timeout();
    `CHK(tk, 16)
    `CHK(smp >= 4 * n - 1 && smp <= 5 * n, 1'b1)
    `CHK(busy >= 16 * n && busy <= 17 * n + 1, 1'b1)
    repeat (2) @(posedge REF_CLK);
    `CHK(CONV_IRQ, irq)
    apb(1'b0, OFS_CTRL_A, 32'h0);
    `CHK(rd, 32'h0000_0005)
    apb(1'b0, OFS_IRQ, 32'h0);
    `CHK(rd[IRQ_FLAG], 1'b1)
    apb(1'b0, OFS_RESULT_LOW, 32'h0);
    `CHK(rd, {24'h0, raw[7:0]})
    apb(1'b0, OFS_RESULT_HIGH, 32'h0);
    `CHK(rd, {28'h0, raw[11:8]})
  endtask

  task automatic t_reset_and_off();
    apb(1'b0, OFS_CTRL_A, 32'h0);
    `CHK(rd, 32'h0000_0060)
    apb(1'b0, OFS_CTRL_B, 32'h0);
    `CHK(rd, 32'h0000_0080)
    apb(1'b0, 8'h18, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Pulse while powered off must not launch anything
    apb(1'b1, OFS_CTRL_A, 32'h0000_00A0);
    apb(1'b1, OFS_CTRL_A, 32'h0000_0020);
    repeat (20) @(posedge REF_CLK);
    `CHK({CONV_POWER_EN, CONV_SAMPLE, CONV_CONVERT}, 3'b000)
    apb(1'b0, OFS_CTRL_A, 32'h0);
    `CHK(rd, 32'h0000_0020)
  endtask

  task automatic t_power_ref_chan();
    apb(1'b1, OFS_CTRL_A, 32'h0000_0005);
    repeat (SETTLE_CYCLES + 5) @(posedge REF_CLK);
    `CHK(CONV_POWER_EN, 1'b1)
    `CHK(CHAN_SEL, 3'd5)
    apb(1'b1, OFS_CTRL_B, 32'h0000_0018);
    repeat (2) @(posedge REF_CLK);
    `CHK(REF_SEL_EXT, 1'b1)
    apb(1'b0, OFS_CTRL_B, 32'h0);
    `CHK(rd, 32'h0000_0098)
    apb(1'b1, OFS_CTRL_B, 32'h0);
    repeat (2) @(posedge REF_CLK);
    `CHK(REF_SEL_EXT, 1'b0)
  endtask

  task automatic t_abort();
    apb(1'b1, OFS_CTRL_B, {29'h0, DIV_32});
    apb(1'b1, OFS_CTRL_A, 32'h0000_0085);
    apb(1'b1, OFS_CTRL_A, 32'h0000_0005);
    apb(1'b0, OFS_CTRL_A, 32'h0);
    `CHK(rd, 32'h0000_0045)
    // Start raised mid-conversion resets the converter
    apb(1'b1, OFS_CTRL_A, 32'h0000_0085);
    // The sequencer sees the new start bit one edge after the write lands
    @(posedge REF_CLK);
    #1;
    `CHK({CONV_RESET, CONV_SAMPLE, CONV_CONVERT}, 3'b100)
    apb(1'b0, OFS_CTRL_A, 32'h0);
    `CHK(rd, 32'h0000_0085)
    conv(DIV_32, 32, 1'b0);
  endtask

  task automatic t_irq();
    apb(1'b1, OFS_IRQ, 32'h0000_000E);
    conv(DIV_1, 1, 1'b1);
    apb(1'b1, OFS_IRQ, 32'h0000_0007);
    repeat (2) @(posedge REF_CLK);
    `CHK(CONV_IRQ, 1'b0)
    apb(1'b0, OFS_IRQ, 32'h0);
    `CHK(rd, 32'h0000_0007)
    apb(1'b1, OFS_IRQ, 32'h0000_000E);
    repeat (2) @(posedge REF_CLK);
    `CHK(CONV_IRQ, 1'b0)
    apb(1'b0, OFS_IRQ, 32'h0);
    `CHK(rd, 32'h0000_000E)
  endtask

  task automatic t_pins();
    PORT_OUT <= 8'hA5;
    PORT_OE <= 8'hF0;
    PORT_PULLUP <= 8'h3C;
    apb(1'b1, OFS_PORT_B_FUNC, 32'h0000_0081);
    repeat (3) @(posedge REF_CLK);
    `CHK(PIN_ANALOG_EN, 8'h81)
    `CHK(PIN_OUT, 8'h24)
    `CHK(PIN_PULLUP_EN, 8'h3C)
    `CHK(PIN_OE, 8'h70)
    PORT_PULLUP <= 8'hFF;
    PORT_OE <= 8'hFF;
    repeat (3) @(posedge REF_CLK);
    `CHK(PIN_PULLUP_EN, 8'h7E)
    `CHK(PIN_OE, 8'h7E)
    apb(1'b1, OFS_CTRL_A, 32'h0000_0020);
    repeat (2) @(posedge REF_CLK);
    `CHK(CONV_POWER_EN, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge REF_CLK);
    RESETN <= 1'b1;
    t_reset_and_off();
    t_power_ref_chan();
    for (int k = 0; k < 8; k++) begin
      conv(codes[k], ratio[k], 1'b0);
    end
    t_abort();
    t_irq();
    t_pins();
    finish_test();
  end
endmodule // tb
